// ==== sbpr_axi_master.sv ====
// axi4-lite master standing in for the link controller
`timescale 1ns/10ps
module sbpr_axi_master (
  input  wire        aclk,
  output logic [5:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic        s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [5:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 41'h0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 8'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      // released lines no longer show the old value
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'h0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'h0, 24'hFFFFFF, ~d};
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'h0, ~a};
    end while (s_axi_rvalid !== 1'h1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask
endmodule // sbpr_axi_master

// ==== sbpr_consts.vh ====
// constants of the serial bus phy base register bank
`ifndef SBPR_CONSTS_VH
`define SBPR_CONSTS_VH
`define SBPR_IDX_NODE       4'h0
`define SBPR_IDX_GAP        4'h1
`define SBPR_IDX_EXT        4'h2
`define SBPR_IDX_SPEED      4'h3
`define SBPR_IDX_LINK       4'h4
`define SBPR_IDX_IRQ        4'h5
`define SBPR_IDX_RSVD6      4'h6
`define SBPR_IDX_PAGE       4'h7
`define SBPR_ADDR_W         6
`define SBPR_GAP_RESET      6'h3F
`define SBPR_EXT_VALUE      3'h7
`define SBPR_PORTS_VALUE    4'h6
`define SBPR_SPEED_VALUE    3'h2
`define SBPR_DELAY_VALUE    4'h0
`define SBPR_JITTER_VALUE   3'h0
`define SBPR_LINK_RESET     1'h1
`define SBPR_PAGE_RSVD_LO   3'h2
`define SBPR_PAGE_RSVD_HI   3'h6
`define SBPR_GAP_RHB_BIT    7
`define SBPR_GAP_IBR_BIT    6
`define SBPR_LNK_L_BIT      7
`define SBPR_LNK_C_BIT      6
`define SBPR_IRQ_RESUME_INTERRUPT_ENABLE_BIT   7
`define SBPR_IRQ_SHORT_RESET_REQUEST_BIT   6
`define SBPR_IRQ_CONFIGURATION_TIMEOUT_FLAG_BIT   5
`define SBPR_IRQ_CABLE_POWER_DROP_FLAG_BIT   4
`define SBPR_IRQ_STATE_TIMEOUT_FLAG_BIT   3
`define SBPR_IRQ_PEI_BIT    2
`define SBPR_IRQ_EAA_BIT    1
`define SBPR_IRQ_EMC_BIT    0
`define SBPR_RESP_OKAY      2'h0
`define SBPR_RESP_SLVERR    2'h2
`endif

// ==== sbpr_regs.v ====
// serial bus phy base register bank with axi4-lite slave
`timescale 1ns/10ps
`include "sbpr_consts.vh"
// Operation
// - sixteen registers: eight fixed base, eight paged at 8 to 15.
// - eight pages; page chosen by page-select field in register 7.
// - base register layout does not depend on the selected page.
// - reserved registers and fields read as zero.
// - pages two through six read entirely as zero.
// - register 0: node identifier, root flag, cable-power flag.
// - node id invalid from bus reset until self-id; then status transfer.
// - root flag clears on bus reset, sets when node becomes root.
// - cable-power flag mirrors the cable-power sense input.
// - root request bit: writable, cleared by hardware reset only.
// - long reset request starts long bus reset when idle; clears on resets.
// - six-bit gap count loaded by register write or config packet.
// - gap count 3Fh on hardware reset or two resets without update.
// - extended-set field in register 2 reads 111b.
// - port-count field in register 2 reads six.
// - speed field in register 3 reads 010b.
// - register 3 delay reads 0000b and jitter reads 000.
// - register 7 holds reserved bit, port select, page select; 6 reserved.
// - short reset request starts short reset when idle; clears on bus reset.
// - cable-power-drop flag sets on falling sense; write one clears.
// - configuration-timeout flag sets on event; write one clears.
// - contender and power class load from pins at hardware reset.
module sbpr_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bus_reset,
  input  wire        self_id_done,
  input  wire [5:0]  self_id_node,
  input  wire        root_won,
  input  wire        cable_power_sense,
  input  wire        config_timeout_event,
  input  wire        state_timeout_event,
  input  wire        port_event,
  input  wire        resume_event,
  input  wire        config_gap_load,
  input  wire [5:0]  config_gap_value,
  input  wire        link_idle,
  input  wire        contender_linkon_pin,
  input  wire [2:0]  power_class_pins,
  output reg  [5:0]  node_identifier,
  output reg         node_id_valid,
  output reg         status_transfer,
  output reg         root_request_bit,
  output reg  [5:0]  gap_count,
  output reg         long_reset_start,
  output reg         short_reset_start,
  output reg         link_active,
  output reg         contender,
  output reg  [2:0]  power_class,
  output reg         arbitration_acceleration_enable,
  output reg         multispeed_concatenation_enable,
  output reg  [3:0]  port_select,
  output reg  [2:0]  page_select
);

  reg       root_flag;
  reg       cable_power_flag;
  reg       cps_prev;
  reg       long_reset_request;
  reg       short_reset_request;
  reg       reset_issued;
  reg       gap_updated;
  reg       strap_pending;
  reg       resume_interrupt_enable;
  reg       configuration_timeout_flag;
  reg       cable_power_drop_flag;
  reg       state_timeout_flag;
  reg       port_event_flag;
  reg       aw_held;
  reg       w_held;
  reg [5:0] aw_addr;
  reg [7:0] w_byte;
  reg       w_lane;
  wire      wr_go;
  wire      wr_hit;
  wire [3:0] wr_idx;
  wire [7:0] wd;

  // mapped when the byte address is word aligned; six address bits span all sixteen words
  function in_map;
    input [5:0] a;
    begin
      in_map = (a[1:0] == 2'h0);
    end
  endfunction

  function page_reserved;
    input [2:0] p;
    begin
      page_reserved = (p >= `SBPR_PAGE_RSVD_LO) && (p <= `SBPR_PAGE_RSVD_HI);
    end
  endfunction

  function [7:0] read_reg;
    input [3:0] idx;
    begin
      case (idx)
        `SBPR_IDX_NODE:  read_reg = {node_identifier, root_flag, cable_power_flag};
        `SBPR_IDX_GAP:   read_reg = {root_request_bit, long_reset_request, gap_count};
        `SBPR_IDX_EXT:   read_reg = {`SBPR_EXT_VALUE, 1'b0, `SBPR_PORTS_VALUE};
        `SBPR_IDX_SPEED: read_reg = {`SBPR_SPEED_VALUE, 1'b0, `SBPR_DELAY_VALUE} | {5'h00, `SBPR_JITTER_VALUE};
        `SBPR_IDX_LINK:  read_reg = {link_active, contender, 3'h0, power_class};
        `SBPR_IDX_IRQ:   read_reg = {resume_interrupt_enable, short_reset_request, configuration_timeout_flag,
                                     cable_power_drop_flag, state_timeout_flag, port_event_flag,
                                     arbitration_acceleration_enable, multispeed_concatenation_enable};
        // port and page select with reserved top bit
        `SBPR_IDX_PAGE:  read_reg = {1'b0, port_select, page_select};
        // reserved register six and paged registers read zero
        default:         read_reg = 8'h00;
      endcase
    end
  endfunction

  // paged space never aliases base fields; no page content is implemented
  function [7:0] read_any;
    input [3:0] idx;
    begin
      if (!idx[3])
        read_any = read_reg(idx);
      else if (page_reserved(page_select))
        read_any = 8'h00;
      else
        read_any = 8'h00;
    end
  endfunction

  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = wr_go && w_lane && in_map(aw_addr);
  assign wr_idx = aw_addr[5:2];
  assign wd     = w_byte;

  // axi write address and data capture, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 6'h00;
      w_byte        <= 8'h00;
      w_lane        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SBPR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= in_map(aw_addr) ? `SBPR_RESP_OKAY : `SBPR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel, one cycle answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SBPR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (in_map(s_axi_araddr)) begin
          s_axi_rdata <= {24'h000000, read_any(s_axi_araddr[5:2])};
          s_axi_rresp <= `SBPR_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SBPR_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // node status, root, cable power
  always @(posedge aclk) begin
    if (!aresetn) begin
      node_identifier  <= 6'h00;
      node_id_valid    <= 1'b0;
      status_transfer  <= 1'b0;
      root_flag        <= 1'b0;
      cable_power_flag <= 1'b0;
      cps_prev         <= 1'b0;
    end else begin
      cable_power_flag <= cable_power_sense;
      cps_prev         <= cable_power_sense;
      status_transfer  <= 1'b0;
      // invalid from bus reset until self-id, then status transfer
      if (bus_reset) begin
        node_id_valid <= 1'b0;
      end else if (self_id_done) begin
        node_identifier <= self_id_node;
        node_id_valid   <= 1'b1;
        status_transfer <= 1'b1;
      end
      if (bus_reset)
        root_flag <= 1'b0;
      else if (root_won)
        root_flag <= 1'b1;
    end
  end

  // writable and event-driven fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      root_request_bit                <= 1'b0;
      long_reset_request              <= 1'b0;
      short_reset_request             <= 1'b0;
      reset_issued                    <= 1'b0;
      long_reset_start                <= 1'b0;
      short_reset_start               <= 1'b0;
      gap_count                       <= `SBPR_GAP_RESET;
      gap_updated                     <= 1'b0;
      link_active                     <= `SBPR_LINK_RESET;
      contender                       <= 1'b0;
      power_class                     <= 3'h0;
      strap_pending                   <= 1'b1;
      resume_interrupt_enable         <= 1'b0;
      configuration_timeout_flag      <= 1'b0;
      cable_power_drop_flag           <= 1'b0;
      state_timeout_flag              <= 1'b0;
      port_event_flag                 <= 1'b0;
      arbitration_acceleration_enable <= 1'b0;
      multispeed_concatenation_enable <= 1'b0;
      port_select                     <= 4'h0;
      page_select                     <= 3'h0;
    end else begin
      long_reset_start  <= 1'b0;
      short_reset_start <= 1'b0;
      // straps caught on first cycle after reset release
      strap_pending <= 1'b0;
      if (strap_pending) begin
        contender   <= contender_linkon_pin;
        power_class <= power_class_pins;
      end
      // only writable fields take write data
      if (wr_hit) begin
        case (wr_idx)
          `SBPR_IDX_GAP: begin
            root_request_bit   <= wd[`SBPR_GAP_RHB_BIT];
            long_reset_request <= wd[`SBPR_GAP_IBR_BIT];
          end
          `SBPR_IDX_LINK: begin
            link_active <= wd[`SBPR_LNK_L_BIT];
            if (!strap_pending) begin
              contender   <= wd[`SBPR_LNK_C_BIT];
              power_class <= wd[2:0];
            end
          end
          `SBPR_IDX_IRQ: begin
            resume_interrupt_enable         <= wd[`SBPR_IRQ_RESUME_INTERRUPT_ENABLE_BIT];
            short_reset_request             <= wd[`SBPR_IRQ_SHORT_RESET_REQUEST_BIT];
            arbitration_acceleration_enable <= wd[`SBPR_IRQ_EAA_BIT];
            multispeed_concatenation_enable <= wd[`SBPR_IRQ_EMC_BIT];
          end
          `SBPR_IDX_PAGE: begin
            port_select <= wd[6:3];
            page_select <= wd[2:0];
          end
          default: begin
          end
        endcase
      end
      // gap count load and two-reset default
      if (bus_reset) begin
        if (!gap_updated)
          gap_count <= `SBPR_GAP_RESET;
        gap_updated <= 1'b0;
      end else if (config_gap_load) begin
        gap_count   <= config_gap_value;
        gap_updated <= 1'b1;
      end else if (wr_hit && wr_idx == `SBPR_IDX_GAP) begin
        gap_count   <= wd[5:0];
        gap_updated <= 1'b1;
      end
      // reset requests clear on bus reset, start once when idle
      if (bus_reset) begin
        long_reset_request  <= 1'b0;
        short_reset_request <= 1'b0;
        reset_issued        <= 1'b0;
      end else if (!reset_issued && link_idle && (long_reset_request || short_reset_request)) begin
        reset_issued      <= 1'b1;
        long_reset_start  <= long_reset_request;
        short_reset_start <= !long_reset_request;
      end
      // sticky flags, set wins over write-one clear
      if (wr_hit && wr_idx == `SBPR_IDX_IRQ) begin
        if (wd[`SBPR_IRQ_CONFIGURATION_TIMEOUT_FLAG_BIT])
          configuration_timeout_flag <= 1'b0;
        if (wd[`SBPR_IRQ_CABLE_POWER_DROP_FLAG_BIT])
          cable_power_drop_flag <= 1'b0;
        if (wd[`SBPR_IRQ_STATE_TIMEOUT_FLAG_BIT])
          state_timeout_flag <= 1'b0;
        if (wd[`SBPR_IRQ_PEI_BIT])
          port_event_flag <= 1'b0;
      end
      if (config_timeout_event)
        configuration_timeout_flag <= 1'b1;
      if (cps_prev && !cable_power_sense)
        cable_power_drop_flag <= 1'b1;
      if (state_timeout_event)
        state_timeout_flag <= 1'b1;
      if (port_event || (resume_event && resume_interrupt_enable))
        port_event_flag <= 1'b1;
    end
  end

endmodule // sbpr_regs

// ==== sbpr_regs_sva.sv ====
// assertions on the base register bank ports
`timescale 1ns/10ps
module sbpr_regs_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire        bus_reset,
  input wire        self_id_done,
  input wire [5:0]  self_id_node,
  input wire        config_gap_load,
  input wire [5:0]  config_gap_value,
  input wire [5:0]  gap_count,
  input wire [5:0]  node_identifier,
  input wire        node_id_valid,
  input wire        status_transfer,
  input wire        long_reset_start,
  input wire        link_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_gap_hwrst: assert property (
    $rose(aresetn) |-> gap_count == 6'h3F && link_active) else $error("gap count not 3F after reset");
  a_id_load: assert property (
    self_id_done && !bus_reset |=> node_id_valid && node_identifier == $past(self_id_node))
    else $error("node id not loaded");
  a_id_invalid: assert property (
    bus_reset && !self_id_done |=> !node_id_valid) else $error("node id valid after bus reset");
  a_status_xfer: assert property (
    self_id_done && !bus_reset |-> ##[1:2] status_transfer) else $error("no status transfer");
  a_cfg_gap: assert property (
    config_gap_load && !bus_reset |=> gap_count == $past(config_gap_value)) else $error("gap not loaded");
  a_long_once: assert property (
    long_reset_start |=> !long_reset_start [*4]) else $error("long reset start repeated");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  a_rd_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
  a_wr_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answered twice");
  c_status: cover property (status_transfer);
  c_long: cover property (long_reset_start);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_cfg: cover property (config_gap_load);
endmodule // sbpr_regs_chk
bind sbpr_regs sbpr_regs_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .bus_reset(bus_reset),
  .self_id_done(self_id_done), .self_id_node(self_id_node), .config_gap_load(config_gap_load),
  .config_gap_value(config_gap_value), .gap_count(gap_count), .node_identifier(node_identifier),
  .node_id_valid(node_id_valid), .status_transfer(status_transfer), .long_reset_start(long_reset_start),
  .link_active(link_active));

// ==== testbench.sv ====
// self-checking bench for the base register bank
`timescale 1ns/10ps
`include "sbpr_consts.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr, self_id_node, config_gap_value;
  logic [31:0] s_axi_wdata, s_axi_rdata, d32;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r2;
  logic [6:0]  ev;
  logic        cable_power_sense, link_idle, contender_linkon_pin, long_reset_start, short_reset_start;
  logic [2:0]  power_class_pins, pwr, page;
  int          failures, n_tests, nl, ns;
  logic [5:0]  nid, gap;
  logic [3:0]  port, ri;
  logic [7:0]  r5;
  logic        root, rreq, lreq, lnk, con, upd;
  logic        resume, o_rreq, o_lnk, o_con, o_eaa, o_emc;
  logic [5:0]  o_nid, o_gap;
  logic [3:0]  o_port;
  logic [2:0]  o_pwr, o_page;
  sbpr_axi_master i_mst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sbpr_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus_reset(ev[0]), .self_id_done(ev[1]), .self_id_node, .root_won(ev[2]), .cable_power_sense,
    .config_timeout_event(ev[3]), .state_timeout_event(ev[4]), .port_event(ev[5]), .resume_event(resume),
    .config_gap_load(ev[6]), .config_gap_value, .link_idle, .contender_linkon_pin, .power_class_pins,
    .node_identifier(o_nid), .node_id_valid(), .status_transfer(), .root_request_bit(o_rreq), .gap_count(o_gap),
    .long_reset_start, .short_reset_start, .link_active(o_lnk), .contender(o_con), .power_class(o_pwr),
    .arbitration_acceleration_enable(o_eaa), .multispeed_concatenation_enable(o_emc), .port_select(o_port),
    .page_select(o_page));
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [7:0] exp_reg(input logic [3:0] i);
    case (i)
      4'h0: return {nid, root, cable_power_sense};
      4'h1: return {rreq, lreq, gap};
      4'h2: return 8'hE6;
      4'h3: return 8'h40;
      4'h4: return {lnk, con, 3'h0, pwr};
      4'h5: return r5;
      4'h7: return {1'h0, port, page};
      default: return 8'h0;
    endcase
  endfunction
  task automatic chk(input logic [3:0] i);
    i_mst.rd({i, 2'h0}, d32, r2);
    `CHK("rdata", {24'h0, exp_reg(i)}, d32)
    `CHK("rresp", `SBPR_RESP_OKAY, r2)
    case (i)
      4'h0: `CHK("node id out", nid, o_nid)
      4'h1: `CHK("gap out", {rreq, gap}, {o_rreq, o_gap})
      4'h4: `CHK("link out", {lnk, con, pwr}, {o_lnk, o_con, o_pwr})
      4'h5: `CHK("feature out", r5[1:0], {o_eaa, o_emc})
      4'h7: `CHK("select out", {port, page}, {o_port, o_page})
      default: ;
    endcase
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    i_mst.wr({i, 2'h0}, d, r2);
    `CHK("bresp", `SBPR_RESP_OKAY, r2)
    case (i)
      4'h1: {rreq, lreq, gap, upd} = {d, 1'h1};
      4'h4: {lnk, con, pwr} = {d[7:6], d[2:0]};
      4'h5: r5 = {d[7:6], r5[5:2] & ~d[5:2], d[1:0]};
      4'h7: {port, page} = d[6:0];
      default: ;
    endcase
  endtask
  task automatic fire(input logic [6:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 7'h0;
    @(posedge aclk);
  endtask
  task automatic breset;
    fire(7'h01);
    {root, lreq, r5[6]} = 3'h0;
    if (!upd) gap = 6'h3F;
    upd = 1'h0;
  endtask
  task automatic hw_reset;
    contender_linkon_pin <= 1'($urandom);
    power_class_pins <= 3'($urandom);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    {nid, root, rreq, lreq, gap, upd} = {9'h0, 6'h3F, 1'h0};
    {lnk, con, pwr, r5, port, page} = {1'h1, contender_linkon_pin, power_class_pins, 15'h0};
    repeat (2) @(posedge aclk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end
  initial begin
    {ev, link_idle, self_id_node, config_gap_value} <= 20'h0;
    cable_power_sense <= 1'h1;
    resume <= 1'h0;
    void'($urandom(13));
    nl = 0;
    ns = 0;
    hw_reset();
    for (int i = 0; i < 16; i++) chk(4'(i));
    chk(4'h2);
    chk(4'h3);
    $display("test reset values done");
    for (int p = 0; p < 8; p++) begin
      wr(4'h7, {5'($urandom), p[2:0]});
      for (int j = 8; j < 16; j++) chk(4'(j));
      chk(4'h7);
    end
    $display("test pages done");
    repeat (40) begin
      ri = 4'($urandom);
      wr(ri, 8'($urandom));
      chk(ri);
    end
    i_mst.wr(6'h05, 8'hFF, r2);
    `CHK("bresp bad address", `SBPR_RESP_SLVERR, r2)
    i_mst.rd(6'h05, d32, r2);
    `CHK("rresp bad address", `SBPR_RESP_SLVERR, r2)
    `CHK("rdata bad address", 32'h0, d32)
    $display("test random access done");
    nid = 6'($urandom);
    self_id_node <= nid;
    fire(7'h06);
    root = 1'h1;
    chk(4'h0);
    cable_power_sense <= 1'h0;
    repeat (2) @(posedge aclk);
    r5[4] = 1'h1;
    chk(4'h0);
    chk(4'h5);
    cable_power_sense <= 1'h1;
    fire(7'h08);
    fire(7'h10);
    fire(7'h20);
    r5[5:2] = 4'hF;
    chk(4'h5);
    wr(4'h5, 8'h3C);
    chk(4'h5);
    // resume sets the port event flag only while its enable is set
    for (int k = 0; k < 2; k++) begin
      wr(4'h5, {k[0], 7'h04});
      resume <= 1'h1;
      @(posedge aclk);
      resume <= 1'h0;
      repeat (2) @(posedge aclk);
      r5[2] = k[0];
      chk(4'h5);
    end
    $display("test events done");
    wr(4'h1, 8'h80 | (8'($urandom) & 8'h3F));
    breset();
    chk(4'h1);
    chk(4'h0);
    breset();
    chk(4'h1);
    config_gap_value <= 6'($urandom);
    fire(7'h40);
    {gap, upd} = {config_gap_value, 1'h1};
    chk(4'h1);
    breset();
    wr(4'h1, {2'h1, gap});
    link_idle <= 1'h1;
    repeat (8) @(posedge aclk) nl += long_reset_start;
    `CHK("long starts", 1, nl)
    breset();
    wr(4'h5, 8'h40);
    repeat (8) @(posedge aclk) ns += short_reset_start;
    `CHK("short starts", 1, ns)
    breset();
    chk(4'h5);
    chk(4'h1);
    $display("test bus resets done");
    hw_reset();
    for (int i = 0; i < 8; i++) chk(4'(i));
    $display("test second reset done");
    give_verdict();
  end
endmodule // testbench
